// File: vds_cfg.svh
// Register offsets, field positions and reset values for the video decoder status bank
`ifndef VDS_CFG_SVH
`define VDS_CFG_SVH

// Sub addresses of the bank
`define VDS_ADDR_REQUEST 8'h0A
`define VDS_ADDR_STATUS 8'h10
`define VDS_ADDR_CP_STATUS 8'h11
`define VDS_ADDR_CAP_LO 8'h12
`define VDS_ADDR_CAP_HI 8'h13
`define VDS_ADDR_EXT_LO 8'h14
`define VDS_ADDR_EXT_HI 8'h15
`define VDS_ADDR_LID_FIRST 8'h16
`define VDS_ADDR_LID_SECOND 8'h17
`define VDS_ADDR_CHIP_ID 8'h18

// Request register fields
`define VDS_REQ_BITS 3
`define VDS_REQ_LINE_ID_BIT 2

// Status register fields
`define VDS_ST_CAP_PRESENT_BIT 5
`define VDS_ST_EXT_PRESENT_BIT 6
`define VDS_ST_LID_PRESENT_BIT 7

// Word widths and reset values
`define VDS_CAP_WIDTH 16
`define VDS_LID_WIDTH 14
`define VDS_WORD_RESET 16'h0000
`define VDS_BYTE_RESET 8'h00

`endif

// File: vds_host_model.sv
// Host controller model that reads and writes the bank through the sub-address port
`timescale 1ns/100ps
`default_nettype none
`include "vds_cfg.svh"

module vds_host_model (
    input wire logic mclk,
    output var vds_pkg::vds_reg_req_t reg_req,
    input wire vds_pkg::vds_reg_rsp_t reg_rsp
);
    import vds_pkg::*;

    // Idle port: no strobe, address and data parked on a pattern
    initial begin
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'h5A, wdata: 8'hA5};
    end

    // One-cycle write strobe; address and data flipped after the edge so a stale value is never seen
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_req.wr = 1'b1;
        reg_req.addr = addr;
        reg_req.wdata = data;
        @(posedge mclk);
        #1;
        reg_req.wr = 1'b0;
        reg_req.addr = ~addr;
        reg_req.wdata = ~data;
    endtask

    // One-cycle read strobe; the answer is registered, so it is taken just after the edge that accepts it
    task automatic read_reg(input logic [7:0] addr, output logic got, output logic [7:0] data);
        @(posedge mclk);
        #1;
        reg_req.rd = 1'b1;
        reg_req.addr = addr;
        @(posedge mclk);
        #1;
        reg_req.rd = 1'b0;
        reg_req.addr = ~addr;
        got = reg_rsp.valid;
        data = reg_rsp.data;
    endtask
endmodule
`default_nettype wire

// File: vds_pkg.sv
// Types shared by the video decoder status bank
package vds_pkg;

    // Copy-protection detector outputs, msb first as laid out in the status byte
    typedef struct packed {
        logic pseudo_sync_found;
        logic gain_pulse_found;
        logic porch_pulse_found;
        logic sync_reduction_found;
        logic stripe_variant;
        logic stripe_process_found;
        logic prot_gain_process_found;
    } vds_cp_flags_t;

    // One access on the sub-address port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vds_reg_req_t;

    // Read answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } vds_reg_rsp_t;

    // Decoded word delivered by a decoder
    typedef struct packed {
        logic load;
        logic [15:0] word;
    } vds_word_in_t;

endpackage

// File: vds_status_regs.sv
// Status and decoded-data register bank of the video decoder
`timescale 1ns/100ps
`default_nettype none
`include "vds_cfg.svh"

// Notes on behaviour
// - Status bit 0 reads 1 while the protection gain process is detected.
// - Status bit 1 reads 1 while a colour stripe process is detected.
// - Status bit 2 gives the stripe variant: 0 type two, 1 type three.
// - Status bit 3 reads 1 when sync amplitude reduction is detected.
// - Status bit 4 reads 1 when an end-of-field porch pulse is detected.
// - Status bit 5 reads 1 when an inserted gain pulse is detected.
// - Status bit 6 reads 1 on pseudo sync pulses; bit 7 reads zero.
// - Caption word low byte at 0x12, high byte at 0x13, read only.
// - Extended caption word low byte at 0x14, high byte at 0x15.
// - Line id bits 1..6 in 0x16 bits 5..0, bits 7..14 in 0x17.
// - Widescreen bits 13..8 go to the first byte, 7..0 to the second.
// - Identifier at 0x18: part code in bits 5..0, revision in 7..6.
// - Present flags set when decoded data of that kind is held.
// - Writing 1 to any request bit clears the three present flags, except a flag whose word loads in that same cycle.
module vds_status_regs
    import vds_pkg::*;
#(
    parameter logic [5:0] PART_CODE = 6'h15, // Arbitrary value
    parameter logic [1:0] REVISION_CODE = 2'h1 // Arbitrary value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire vds_pkg::vds_reg_req_t reg_req,
    output vds_pkg::vds_reg_rsp_t reg_rsp,
    input wire vds_pkg::vds_cp_flags_t cp_flags,
    input wire logic [4:0] front_status,
    input wire vds_pkg::vds_word_in_t caption_in,
    input wire vds_pkg::vds_word_in_t ext_caption_in,
    input wire vds_pkg::vds_word_in_t line_id_in,
    output logic [`VDS_REQ_BITS-1:0] decode_request_r,
    output logic line_id_decode_request
);
    import vds_pkg::*;

    logic [15:0] cap_word;
    logic [15:0] ext_word;
    logic [`VDS_LID_WIDTH-1:0] lid_word;
    logic cap_present;
    logic ext_present;
    logic lid_present;
    logic req_hit;
    logic present_clear;
    vds_cp_flags_t cp_r;
    logic [7:0] rd_data_nxt;
    logic [7:0] rd_data_r;
    logic rd_valid_r;

    // Splits a line-id or widescreen word into its two register bytes
    function automatic logic [7:0] lid_byte(input logic [`VDS_LID_WIDTH-1:0] w, input logic second);
        logic [7:0] b;
        b = 8'h00;
        if (second) begin
            b = w[7:0];
        end else begin
            b = {2'b00, w[13:8]};
        end
        return b;
    endfunction

    // Write that carries a 1 into the request register
    function automatic logic is_req_write(input vds_reg_req_t r);
        return r.wr && (r.addr == `VDS_ADDR_REQUEST) && (|r.wdata[`VDS_REQ_BITS-1:0]);
    endfunction

    assign req_hit = is_req_write(reg_req);
    assign present_clear = req_hit;

    // Caption, extended caption and line-id holders share one module
    vds_word_hold #(.W(`VDS_CAP_WIDTH)) u_caption (
        .mclk(mclk),
        .rst(rst),
        .load(caption_in.load),
        .word(caption_in.word),
        .clear(present_clear),
        .word_r(cap_word),
        .present_r(cap_present)
    );

    vds_word_hold #(.W(`VDS_CAP_WIDTH)) u_ext_caption (
        .mclk(mclk),
        .rst(rst),
        .load(ext_caption_in.load),
        .word(ext_caption_in.word),
        .clear(present_clear),
        .word_r(ext_word),
        .present_r(ext_present)
    );

    vds_word_hold #(.W(`VDS_LID_WIDTH)) u_line_id (
        .mclk(mclk),
        .rst(rst),
        .load(line_id_in.load),
        .word(line_id_in.word[`VDS_LID_WIDTH-1:0]),
        .clear(present_clear),
        .word_r(lid_word),
        .present_r(lid_present)
    );

    // Detector levels are registered so a read sees one consistent byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cp_r <= '0;
        end else begin
            cp_r <= cp_flags;
        end
    end

    // Request bits are one-cycle pulses to the decoders; they never read back
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            decode_request_r <= '0;
        end else if (reg_req.wr && reg_req.addr == `VDS_ADDR_REQUEST) begin
            decode_request_r <= reg_req.wdata[`VDS_REQ_BITS-1:0];
        end else begin
            decode_request_r <= '0;
        end
    end

    assign line_id_decode_request = decode_request_r[`VDS_REQ_LINE_ID_BIT];

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rd_data_nxt = `VDS_BYTE_RESET;
        unique case (reg_req.addr)
            `VDS_ADDR_STATUS: begin
                rd_data_nxt = {lid_present, ext_present, cap_present, front_status};
            end
            `VDS_ADDR_CP_STATUS: begin
                rd_data_nxt = {1'b0, cp_r};
            end
            `VDS_ADDR_CAP_LO: begin
                rd_data_nxt = cap_word[7:0];
            end
            `VDS_ADDR_CAP_HI: begin
                rd_data_nxt = cap_word[15:8];
            end
            `VDS_ADDR_EXT_LO: begin
                rd_data_nxt = ext_word[7:0];
            end
            `VDS_ADDR_EXT_HI: begin
                rd_data_nxt = ext_word[15:8];
            end
            `VDS_ADDR_LID_FIRST: begin
                rd_data_nxt = lid_byte(lid_word, 1'b0);
            end
            `VDS_ADDR_LID_SECOND: begin
                rd_data_nxt = lid_byte(lid_word, 1'b1);
            end
            `VDS_ADDR_CHIP_ID: begin
                rd_data_nxt = {REVISION_CODE, PART_CODE};
            end
            default: begin
                rd_data_nxt = `VDS_BYTE_RESET;
            end
        endcase
    end

    // Read data is captured one cycle after the strobe; writes never reach this path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data_r <= `VDS_BYTE_RESET;
        end else if (reg_req.rd) begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // Answer strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_req.rd;
        end
    end

    assign reg_rsp.valid = rd_valid_r;
    assign reg_rsp.data = rd_data_r;

    // Checks on the bank
    logic rd_cp;
    logic rd_id;
    logic rd_st;
    assign rd_cp = reg_req.rd && reg_req.addr == `VDS_ADDR_CP_STATUS;
    assign rd_id = reg_req.rd && reg_req.addr == `VDS_ADDR_CHIP_ID;
    assign rd_st = reg_req.rd && reg_req.addr == `VDS_ADDR_STATUS;

    AST_CP_GAIN: assert property (@(posedge mclk) disable iff (rst)
        rd_cp |=> reg_rsp.valid && reg_rsp.data[0] == $past(cp_r.prot_gain_process_found))
        else $error("gain process bit wrong");
    AST_CP_STRIPE: assert property (@(posedge mclk) disable iff (rst)
        cp_flags.stripe_process_found ##1 rd_cp |=> reg_rsp.data[1])
        else $error("stripe process bit not reported");
    AST_CP_VARIANT: assert property (@(posedge mclk) disable iff (rst)
        rd_cp |=> reg_rsp.data[2] == $past(cp_r.stripe_variant))
        else $error("stripe variant bit wrong");
    AST_CP_SYNC: assert property (@(posedge mclk) disable iff (rst)
        !cp_flags.sync_reduction_found ##1 rd_cp |=> !reg_rsp.data[3])
        else $error("sync reduction bit wrong");
    AST_CP_PORCH: assert property (@(posedge mclk) disable iff (rst)
        rd_cp |=> reg_rsp.data[4] == $past(cp_r.porch_pulse_found))
        else $error("porch pulse bit wrong");
    AST_CP_PULSE: assert property (@(posedge mclk) disable iff (rst)
        rd_cp |=> reg_rsp.data[5] == $past(cp_r.gain_pulse_found))
        else $error("gain pulse bit wrong");
    AST_CP_PSEUDO: assert property (@(posedge mclk) disable iff (rst)
        rd_cp |=> reg_rsp.data[7:6] == {1'b0, $past(cp_r.pseudo_sync_found)})
        else $error("pseudo sync or reserved bit wrong");
    AST_CAP_LOW: assert property (@(posedge mclk) disable iff (rst)
        caption_in.load ##1 !caption_in.load
        ##1 (reg_req.rd && reg_req.addr == `VDS_ADDR_CAP_LO && !caption_in.load)
        |=> reg_rsp.data == $past(caption_in.word[7:0], 3))
        else $error("caption low byte wrong");
    AST_EXT_HIGH: assert property (@(posedge mclk) disable iff (rst)
        ext_caption_in.load ##1 !ext_caption_in.load
        ##1 (reg_req.rd && reg_req.addr == `VDS_ADDR_EXT_HI && !ext_caption_in.load)
        |=> reg_rsp.data == $past(ext_caption_in.word[15:8], 3))
        else $error("extended caption high byte wrong");
    AST_LID_FIRST: assert property (@(posedge mclk) disable iff (rst)
        line_id_in.load ##1 !line_id_in.load
        ##1 (reg_req.rd && reg_req.addr == `VDS_ADDR_LID_FIRST && !line_id_in.load)
        |=> reg_rsp.data == {2'b00, $past(line_id_in.word[13:8], 3)})
        else $error("line id first byte wrong");
    AST_CHIP_ID: assert property (@(posedge mclk) disable iff (rst)
        rd_id |=> reg_rsp.valid && reg_rsp.data == {REVISION_CODE, PART_CODE})
        else $error("identifier wrong");
    AST_PRESENT_SET: assert property (@(posedge mclk) disable iff (rst)
        caption_in.load ##1 !req_hit ##1 rd_st |=> reg_rsp.data[`VDS_ST_CAP_PRESENT_BIT])
        else $error("caption present not set");
    AST_REQ_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        req_hit && !caption_in.load && !ext_caption_in.load && !line_id_in.load
        |=> !cap_present && !ext_present && !lid_present ##0 decode_request_r != '0)
        else $error("request did not clear present flags");
    AST_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (rst)
        reg_req.wr && reg_req.addr == `VDS_ADDR_CAP_LO && !caption_in.load |=> $stable(cap_word))
        else $error("write altered caption word");

    COV_CAPTION_READ: cover property (@(posedge mclk) disable iff (rst)
        caption_in.load ##[1:4] (reg_req.rd && reg_req.addr == `VDS_ADDR_CAP_HI));
    COV_REQ_CLEAR: cover property (@(posedge mclk) disable iff (rst)
        lid_present ##1 req_hit ##1 !lid_present);
    COV_SET_BEATS_CLEAR: cover property (@(posedge mclk) disable iff (rst)
        req_hit && caption_in.load);
    COV_CP_READ: cover property (@(posedge mclk) disable iff (rst)
        rd_cp && cp_r.stripe_process_found);

endmodule

`default_nettype wire

// File: vds_word_hold.sv
// Holds one decoded word and its data-present flag
`timescale 1ns/100ps
`default_nettype none

module vds_word_hold #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] word,
    input wire logic clear,
    output logic [W-1:0] word_r,
    output logic present_r
);

    generate
        if (W < 1 || W > 16) begin : g_bad_width
            $error("vds_word_hold: W must be 1 to 16");
        end
    endgenerate

    // Word is replaced only by a fresh decode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            word_r <= '0;
        end else if (load) begin
            word_r <= word;
        end
    end

    // A decode landing with a clear keeps the flag set, so no word goes unseen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            present_r <= 1'b0;
        end else if (load) begin
            present_r <= 1'b1;
        end else if (clear) begin
            present_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: video_decoder_status_regs_tb_top.sv
// Self-checking testbench of the video decoder status register bank
`timescale 1ns/100ps
`default_nettype none
`include "vds_cfg.svh"

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end

module video_decoder_status_regs_tb_top;
    import vds_pkg::*;

    localparam logic [5:0] PART_C = 6'h2A; // Arbitrary value
    localparam logic [1:0] REV_C = 2'h2; // Arbitrary value
    localparam int WATCHDOG_NS = 4000 * 5; // Run needs well under 1000 cycles

    logic mclk;
    logic rst;
    vds_reg_req_t reg_req;
    vds_reg_rsp_t reg_rsp;
    vds_cp_flags_t cp_flags;
    logic [4:0] fs;
    vds_word_in_t caption_in;
    vds_word_in_t ext_caption_in;
    vds_word_in_t line_id_in;
    logic [2:0] decode_request_r;
    logic line_id_decode_request;
    int compares = 0;
    int miscompares = 0;

    vds_status_regs #(.PART_CODE(PART_C), .REVISION_CODE(REV_C)) dut_u (
        .mclk(mclk),
        .rst(rst),
        .reg_req(reg_req),
        .reg_rsp(reg_rsp),
        .cp_flags(cp_flags),
        .front_status(fs),
        .caption_in(caption_in),
        .ext_caption_in(ext_caption_in),
        .line_id_in(line_id_in),
        .decode_request_r(decode_request_r),
        .line_id_decode_request(line_id_decode_request)
    );

    vds_host_model host_u (
        .mclk(mclk),
        .reg_req(reg_req),
        .reg_rsp(reg_rsp)
    );

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Read one byte and expect a single valid answer carrying exp
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic got;
        logic [7:0] d;
        host_u.read_reg(addr, got, d);
        `CHK({got, d}, {1'b1, exp})
    endtask

    // Load pulse to the decoders picked by sel, all carrying w
    task automatic load_words(input logic [2:0] sel, input logic [15:0] w);
        @(posedge mclk);
        #1;
        caption_in = '{sel[0], w};
        ext_caption_in = '{sel[1], w};
        line_id_in = '{sel[2], w};
        @(posedge mclk);
        #1;
        caption_in.load = 1'b0;
        ext_caption_in.load = 1'b0;
        line_id_in.load = 1'b0;
    endtask

    // Values after reset, identifier, and places that read zero
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(`VDS_ADDR_CP_STATUS + i), 8'h00);
        end
        rd_chk(`VDS_ADDR_CHIP_ID, {REV_C, PART_C});
        rd_chk(`VDS_ADDR_STATUS, {3'b000, fs});
        rd_chk(`VDS_ADDR_REQUEST, 8'h00);
        rd_chk(8'h3F, 8'h00);
    endtask

    // Each detector level alone, then all of them; bit 7 never sets
    task automatic t_cp();
        for (int i = 0; i < 7; i++) begin
            cp_flags = vds_cp_flags_t'(7'(1 << i));
            rd_chk(`VDS_ADDR_CP_STATUS, 8'(1 << i));
        end
        cp_flags = 7'h7F;
        rd_chk(`VDS_ADDR_CP_STATUS, 8'h7F);
        cp_flags = 7'h00;
        rd_chk(`VDS_ADDR_CP_STATUS, 8'h00);
    endtask

    // Words land byte by byte; the first caption load raises only its own flag; a read right after a load checks the fresh word
    task automatic t_words();
        load_words(3'b001, 16'h6996);
        rd_chk(`VDS_ADDR_STATUS, {3'b001, fs});
        rd_chk(`VDS_ADDR_CAP_HI, 8'h69);
        load_words(3'b001, 16'hA55A);
        rd_chk(`VDS_ADDR_CAP_LO, 8'h5A);
        rd_chk(`VDS_ADDR_CAP_HI, 8'hA5);
        load_words(3'b010, 16'h3CC3);
        rd_chk(`VDS_ADDR_EXT_HI, 8'h3C);
        rd_chk(`VDS_ADDR_EXT_LO, 8'hC3);
        load_words(3'b100, 16'hEAB7);
        rd_chk(`VDS_ADDR_LID_FIRST, 8'h2A);
        rd_chk(`VDS_ADDR_LID_SECOND, 8'hB7);
        rd_chk(`VDS_ADDR_STATUS, {3'b111, fs});
    endtask

    // Writes to every read-only place change nothing and raise no request
    task automatic t_ignore();
        for (int i = 0; i < 9; i++) begin
            host_u.write_reg(8'(`VDS_ADDR_STATUS + i), 8'hFF);
            `CHK(decode_request_r, 3'b000)
        end
        rd_chk(`VDS_ADDR_CAP_LO, 8'h5A);
        rd_chk(`VDS_ADDR_CHIP_ID, {REV_C, PART_C});
        rd_chk(`VDS_ADDR_STATUS, {3'b111, fs});
    endtask

    // Every request bit pulses once and clears the present flags; the data is read only after the same-cycle load below
    task automatic t_request();
        for (int b = 0; b < 3; b++) begin
            load_words(3'b111, 16'h1234);
            host_u.write_reg(`VDS_ADDR_REQUEST, 8'(1 << b));
            `CHK(decode_request_r, 3'(1 << b))
            `CHK(line_id_decode_request, (b == 2))
            rd_chk(`VDS_ADDR_STATUS, {3'b000, fs});
            `CHK(decode_request_r, 3'b000)
        end
        // A load in the same cycle as a request keeps its flag set
        fork
            load_words(3'b111, 16'h1234);
            host_u.write_reg(`VDS_ADDR_REQUEST, 8'h01);
        join
        rd_chk(`VDS_ADDR_STATUS, {3'b111, fs});
        rd_chk(`VDS_ADDR_CAP_LO, 8'h34);
        rd_chk(`VDS_ADDR_LID_FIRST, 8'h12);
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        #(WATCHDOG_NS);
        miscompares++;
        stop_test();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        cp_flags = 7'h00;
        fs = 5'h15;
        caption_in = '0;
        ext_caption_in = '0;
        line_id_in = '0;
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_reset();
        t_cp();
        fs = 5'h0A;
        t_words();
        t_ignore();
        t_request();
        stop_test();
    end
endmodule
`default_nettype wire
